// File: verilog/pidreg_top.sv
// Summary of operation
// RULE1 - New output is previous output plus Kp times weighted present minus previous error
// RULE2 - One sample and one output update every fifty milliseconds
// RULE3 - Output is a percentage held between zero and one hundred
// RULE4 - Kp is the proportional setting; Ki is integral setting times one hundred
// RULE5 - Kd is the differential setting times one hundred
// RULE6 - Error is setpoint minus analog feedback; previous error kept for next sample
// RULE7 - Gains accept 0 to 30.000, defaults 1.000, 0.430 and 0.000
// RULE8 - Source code 0 keypad, 1 analog, 2 serial word, 3 fieldbus word
// RULE9 - Keypad source uses the stored keypad setpoint
// RULE10 - Analog source needs an input set to function 5, else alarm
// RULE11 - Serial word value 1000 means one hundred percent
// RULE12 - Fieldbus word value 1000 means one hundred percent
// RULE13 - Feedback scale 0.0 to 3000.0 scales setpoint and feedback monitors
// RULE14 - Scaled monitors always carry exactly one decimal place
// RULE15 - Scaled setpoint and feedback monitors are read only, up to 3000.0
// RULE16 - Read-only monitor shows present output in percent
// RULE17 - Setpoint smoothing filter time constant 0.00 to 650.00 s, default 0.25 s
// RULE18 - Output saturates and the saturated value becomes the previous output
// RULE19 - First-order low-pass per sample; zero time constant passes setpoint through
`timescale 1ns/1ns
`default_nettype none
module pidreg_top #(
   parameter int SAMPLE_TICKS = pidreg_pkg::SAMPLE_CYCLES // Clocks per sample
) (
   input wire logic CLK,                  // 50 MHz clock
   input wire logic RST_N,                // Async reset, active low
   input wire logic [3:0] ADDR,           // Register word index
   input wire logic [15:0] WDATA,         // Write data
   input wire logic WR,                   // Write strobe
   input wire logic RD,                   // Read strobe
   output logic [15:0] RDATA,             // Read data, cycle after RD
   input wire logic [15:0] FEEDBACK,      // Feedback, tenths of percent
   input wire logic [15:0] ANALOG_SP,     // Analog setpoint, tenths of percent
   input wire logic [15:0] SERIAL_SP,     // Serial setpoint word
   input wire logic [15:0] FIELDBUS_SP,   // Fieldbus setpoint word
   input wire logic [1:0] SRC_SEL,        // Setpoint source selector
   input wire logic [3:0] AIN1_FUNC,      // Analog input 1 function code
   input wire logic [3:0] AIN2_FUNC,      // Analog input 2 function code
   output logic [15:0] OUTPUT_PCT,        // Regulator output, tenths of percent
   output logic SAMPLE_DONE,              // Pulse when output updated
   output logic SRC_ALARM                 // Analog source unset alarm
);
   import pidreg_pkg::*;

   // Off-domain pin inputs pass two flip-flops
   logic [15:0] fb_m, fb_s, asp_m, asp_s, ssp_m, ssp_s, fsp_m, fsp_s;
   logic [1:0] sel_m, sel_s;
   logic [3:0] a1_m, a1_s, a2_m, a2_s;
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         {fb_m, fb_s, asp_m, asp_s, ssp_m, ssp_s, fsp_m, fsp_s} <= '0;
         {sel_m, sel_s, a1_m, a1_s, a2_m, a2_s} <= '0;
      end else begin
         fb_m <= FEEDBACK;
         fb_s <= fb_m;
         asp_m <= ANALOG_SP;
         asp_s <= asp_m;
         ssp_m <= SERIAL_SP;
         ssp_s <= ssp_m;
         fsp_m <= FIELDBUS_SP;
         fsp_s <= fsp_m;
         sel_m <= SRC_SEL;
         sel_s <= sel_m;
         a1_m <= AIN1_FUNC;
         a1_s <= a1_m;
         a2_m <= AIN2_FUNC;
         a2_s <= a2_m;
      end
   end

   // Clamp a percent word to 0..1000 tenths
   function automatic logic [15:0] pct_clip(input logic [15:0] v);
      pct_clip = (v > PCT_FULL) ? PCT_FULL : v;
   endfunction

   // Clamp a setting to its upper limit
   function automatic logic [15:0] lim(input logic [15:0] v, input logic [15:0] m);
      lim = (v > m) ? m : v;
   endfunction

   // Writable settings
   logic [15:0] kp, ki, kd, filt_t, fb_scale, keypad_sp;
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         kp <= RST_KP; // see RULE7
         ki <= RST_KI;
         kd <= RST_KD;
         filt_t <= RST_FILT_T; // see RULE17
         fb_scale <= RST_FB_SCALE;
         keypad_sp <= RST_KEYPAD_SP;
      end else if (WR) begin
         case (ADDR)
            ADDR_KP: kp <= lim(WDATA, GAIN_MAX); // see RULE7
            ADDR_KI: ki <= lim(WDATA, GAIN_MAX);
            ADDR_KD: kd <= lim(WDATA, GAIN_MAX);
            ADDR_FILT_T: filt_t <= lim(WDATA, FILT_T_MAX); // see RULE17
            ADDR_FB_SCALE: fb_scale <= lim(WDATA, SCALE_MAX); // see RULE13
            ADDR_KEYPAD_SP: keypad_sp <= pct_clip(WDATA);
            default: ;
         endcase
      end
   end

   // Sample period divider
   logic [31:0] tick_cnt;
   logic tick;
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         tick_cnt <= '0;
      end else if (tick) begin
         tick_cnt <= '0;
      end else begin
         tick_cnt <= tick_cnt + 32'h1;
      end
   end
   assign tick = (tick_cnt == 32'(SAMPLE_TICKS - 1)); // see RULE2

   // Setpoint source mux; 1000 in any word means 100.0 %
   logic [15:0] raw_sp;
   logic alarm_now;
   always_comb begin
      alarm_now = 1'b0;
      case (sel_s)
         2'd0: raw_sp = keypad_sp; // see RULE9
         2'd1: begin
            raw_sp = pct_clip(asp_s);
            alarm_now = (a1_s != AIN_FUNC_SETPOINT) && (a2_s != AIN_FUNC_SETPOINT); // see RULE10
         end
         2'd2: raw_sp = pct_clip(ssp_s); // see RULE11
         2'd3: raw_sp = pct_clip(fsp_s); // see RULE12
         default: raw_sp = keypad_sp;
      endcase
   end // see RULE8

   // Alarm held while the analog source lacks an assigned input
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         SRC_ALARM <= 1'b0;
      end else begin
         SRC_ALARM <= alarm_now; // see RULE10
      end
   end

   // Update pipeline: filter, then PID, then publish
   pidreg_state_type state, next_state;
   always_comb begin
      case (state)
         ST_IDLE: next_state = tick ? ST_FILT : ST_IDLE;
         ST_FILT: next_state = ST_PID;
         ST_PID: next_state = ST_DONE;
         ST_DONE: next_state = ST_IDLE;
         default: next_state = ST_IDLE;
      endcase
   end
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // First-order filter, alpha = Ta/(T+Ta); T in hundredths so Ta = 5
   // Setpoint held with 16 fraction bits to avoid stalling on small steps
   logic [31:0] sp_filt;
   logic signed [33:0] sp_diff;
   logic [31:0] sp_step;
   logic [16:0] filt_den;
   assign filt_den = {1'b0, filt_t} + 17'd5;
   assign sp_diff = $signed({2'b00, raw_sp, 16'h0000}) - $signed({2'b00, sp_filt});
   assign sp_step = 32'((sp_diff < 0 ? -sp_diff : sp_diff) * 5 / filt_den);
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         sp_filt <= '0;
      end else if (state == ST_FILT) begin
         if (filt_t == 16'h0000) begin
            sp_filt <= {raw_sp, 16'h0000}; // see RULE19
         end else if (sp_diff < 0) begin
            sp_filt <= sp_filt - sp_step; // see RULE17
         end else begin
            sp_filt <= sp_filt + sp_step; // see RULE19
         end
      end
   end

   // Incremental PID in tenths of percent. With gains in thousandths:
   // Kp*(1 + Ki*100*0.05 + Kd*100/0.05) -> kp*(1000 + 5*ki + 2000*kd)/1e6
   logic signed [16:0] err, err_prev;
   logic signed [47:0] coef0, coef1, delta, y_new;
   logic [15:0] sp_now, fb_pct;
   assign sp_now = sp_filt[31:16];
   // Feedback beyond full scale is clipped so error and monitor stay bounded
   assign fb_pct = pct_clip(fb_s);
   assign err = $signed({1'b0, sp_now}) - $signed({1'b0, fb_pct}); // see RULE6
   assign coef0 = 48'sd1000 + 48'sd5 * $signed({32'h0, ki}) // see RULE4
                  + 48'sd2000 * $signed({32'h0, kd}); // see RULE5
   assign coef1 = 48'sd2000 * $signed({32'h0, kd});
   // Full product kept in 72 bits: at 30.000 gains it outgrows 48 bits
   // and would wrap, flipping the sign of the step before saturation
   logic signed [71:0] prod;
   assign prod = $signed({56'h0, kp}) * (coef0 * err - coef1 * err_prev);
   assign delta = 48'(prod / 72'sd1000000); // see RULE1
   assign y_new = $signed({32'h0, OUTPUT_PCT}) + delta;

   logic [15:0] fb_keep;
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         OUTPUT_PCT <= '0;
         err_prev <= '0;
         fb_keep <= '0;
      end else if (state == ST_PID) begin
         if (y_new < 0) begin
            OUTPUT_PCT <= '0; // see RULE18
         end else if (y_new > $signed({32'h0, PCT_FULL})) begin
            OUTPUT_PCT <= PCT_FULL; // see RULE3
         end else begin
            OUTPUT_PCT <= y_new[15:0]; // see RULE1
         end
         err_prev <= err; // see RULE6
         fb_keep <= fb_pct;
      end
   end

   // Sample completion pulse
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         SAMPLE_DONE <= 1'b0;
      end else begin
         SAMPLE_DONE <= (state == ST_PID);
      end
   end

   // Scaled monitors: percent tenths * scale tenths / 1000 stays in tenths
   logic [15:0] sp_mon, fb_mon;
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         sp_mon <= '0;
         fb_mon <= '0;
      end else if (state == ST_DONE) begin
         sp_mon <= 16'((32'(sp_now) * 32'(fb_scale)) / 32'(PCT_FULL)); // see RULE13
         fb_mon <= 16'((32'(fb_keep) * 32'(fb_scale)) / 32'(PCT_FULL)); // see RULE14
      end
   end

   // Read port; monitor writes ignored since no write decode exists for them
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         RDATA <= '0;
      end else if (RD) begin
         case (ADDR)
            ADDR_VERSION: RDATA <= APP_VERSION;
            ADDR_SP_MON: RDATA <= sp_mon; // see RULE15
            ADDR_FB_MON: RDATA <= fb_mon; // see RULE15
            ADDR_OUT_MON: RDATA <= OUTPUT_PCT; // see RULE16
            ADDR_SRC_SEL: RDATA <= {14'h0, sel_s};
            ADDR_FB_SCALE: RDATA <= fb_scale;
            ADDR_KP: RDATA <= kp;
            ADDR_KI: RDATA <= ki;
            ADDR_KD: RDATA <= kd;
            ADDR_FILT_T: RDATA <= filt_t;
            ADDR_KEYPAD_SP: RDATA <= keypad_sp;
            ADDR_STATUS: RDATA <= {15'h0, SRC_ALARM};
            default: RDATA <= 16'h0000;
         endcase
      end else begin
         RDATA <= 16'h0000;
      end
   end

   // Checks
   property p_out_range;
      @(posedge CLK) disable iff (!RST_N) OUTPUT_PCT <= PCT_FULL;
   endproperty
   a_out_range: assert property (p_out_range) else $error("output over full scale"); // see RULE3
   property p_done_spacing;
      @(posedge CLK) disable iff (!RST_N) SAMPLE_DONE |=> !SAMPLE_DONE [*8];
   endproperty
   a_done_spacing: assert property (p_done_spacing) else $error("samples too close"); // see RULE2
   property p_out_stable;
      @(posedge CLK) disable iff (!RST_N) (state != ST_PID) |=> $stable(OUTPUT_PCT);
   endproperty
   a_out_stable: assert property (p_out_stable) else $error("output moved off sample"); // see RULE1
   property p_pass;
      @(posedge CLK) disable iff (!RST_N)
         (state == ST_FILT && filt_t == 16'h0000) |=> (sp_now == $past(raw_sp));
   endproperty
   a_pass: assert property (p_pass) else $error("zero filter did not pass through"); // see RULE19
   property p_alarm;
      @(posedge CLK) disable iff (!RST_N)
         (sel_s == 2'd1 && a1_s != 4'h5 && a2_s != 4'h5) |=> SRC_ALARM;
   endproperty
   a_alarm: assert property (p_alarm) else $error("missing source alarm"); // see RULE10
   property p_no_alarm;
      @(posedge CLK) disable iff (!RST_N) (sel_s != 2'd1) |=> !SRC_ALARM;
   endproperty
   a_no_alarm: assert property (p_no_alarm) else $error("spurious alarm"); // see RULE8
   property p_err_keep;
      @(posedge CLK) disable iff (!RST_N) (state == ST_PID) |=> (err_prev == $past(err));
   endproperty
   a_err_keep: assert property (p_err_keep) else $error("previous error lost"); // see RULE6
   property p_gain_lim;
      @(posedge CLK) disable iff (!RST_N) (kp <= GAIN_MAX) && (ki <= GAIN_MAX) && (kd <= GAIN_MAX);
   endproperty
   a_gain_lim: assert property (p_gain_lim) else $error("gain over limit"); // see RULE7
   property p_mon_lim;
      @(posedge CLK) disable iff (!RST_N) (sp_mon <= SCALE_MAX) && (fb_mon <= SCALE_MAX);
   endproperty
   a_mon_lim: assert property (p_mon_lim) else $error("monitor over scale"); // see RULE15

   // Pipeline order: a tick starts the filter, filter then PID, PID then pulse
   property p_tick_start;
      @(posedge CLK) disable iff (!RST_N) (tick && state == ST_IDLE) |=> (state == ST_FILT);
   endproperty
   a_tick_start: assert property (p_tick_start) else $error("sample not started"); // see RULE2
   property p_fsm_order;
      @(posedge CLK) disable iff (!RST_N) (state == ST_FILT) |=> (state == ST_PID);
   endproperty
   a_fsm_order: assert property (p_fsm_order) else $error("update skipped"); // see RULE2
   property p_done_pid;
      @(posedge CLK) disable iff (!RST_N) (state == ST_PID) |=> SAMPLE_DONE;
   endproperty
   a_done_pid: assert property (p_done_pid) else $error("no sample pulse"); // see RULE2
   property p_done_state;
      @(posedge CLK) disable iff (!RST_N) SAMPLE_DONE |-> (state == ST_DONE);
   endproperty
   a_done_state: assert property (p_done_state) else $error("stray sample pulse"); // see RULE2

   // Saturated value is what is stored, so the next sample starts from it
   property p_sat_lo;
      @(posedge CLK) disable iff (!RST_N)
         (state == ST_PID && y_new < 0) |=> (OUTPUT_PCT == 16'h0000);
   endproperty
   a_sat_lo: assert property (p_sat_lo) else $error("low saturation missed"); // see RULE18
   property p_sat_hi;
      @(posedge CLK) disable iff (!RST_N)
         (state == ST_PID && y_new > $signed({32'h0, PCT_FULL})) |=> (OUTPUT_PCT == PCT_FULL);
   endproperty
   a_sat_hi: assert property (p_sat_hi) else $error("high saturation missed"); // see RULE3

   // Monitors move only at the end of a sample, so reads between samples agree
   property p_mon_hold;
      @(posedge CLK) disable iff (!RST_N)
         (state != ST_DONE) |=> ($stable(sp_mon) && $stable(fb_mon));
   endproperty
   a_mon_hold: assert property (p_mon_hold) else $error("monitor moved off sample"); // see RULE13

   // Settings and setpoints never leave their legal ranges
   property p_set_lim;
      @(posedge CLK) disable iff (!RST_N) (filt_t <= FILT_T_MAX) && (fb_scale <= SCALE_MAX);
   endproperty
   a_set_lim: assert property (p_set_lim) else $error("setting over limit"); // see RULE17
   property p_keypad_lim;
      @(posedge CLK) disable iff (!RST_N) (keypad_sp <= PCT_FULL);
   endproperty
   a_keypad_lim: assert property (p_keypad_lim) else $error("keypad over full scale"); // see RULE9
   property p_sp_range;
      @(posedge CLK) disable iff (!RST_N) (sp_now <= PCT_FULL) && (raw_sp <= PCT_FULL);
   endproperty
   a_sp_range: assert property (p_sp_range) else $error("setpoint over full scale"); // see RULE11

   // An assigned analog input always silences the alarm
   property p_alarm_off;
      @(posedge CLK) disable iff (!RST_N)
         (a1_s == AIN_FUNC_SETPOINT || a2_s == AIN_FUNC_SETPOINT) |=> !SRC_ALARM;
   endproperty
   a_alarm_off: assert property (p_alarm_off) else $error("alarm despite input"); // see RULE10

   // Main scenarios worth seeing at least once
   c_sat_hi: cover property (@(posedge CLK) disable iff (!RST_N) OUTPUT_PCT == PCT_FULL);
   c_sample: cover property (@(posedge CLK) disable iff (!RST_N) SAMPLE_DONE);
   c_alarm: cover property (@(posedge CLK) disable iff (!RST_N) SRC_ALARM);
   c_sat_lo: cover property (@(posedge CLK) disable iff (!RST_N) state == ST_PID && y_new < 0);
   c_smooth: cover property (@(posedge CLK) disable iff (!RST_N)
      state == ST_FILT && filt_t != 16'h0000 && sp_diff != 0);
endmodule
`default_nettype wire

// File: verilog/pidreg_pkg.sv
package pidreg_pkg;
   // Register word indices (byte address is four times the index)
   localparam logic [3:0] ADDR_VERSION = 4'h0;
   localparam logic [3:0] ADDR_SP_MON = 4'h1;
   localparam logic [3:0] ADDR_FB_MON = 4'h2;
   localparam logic [3:0] ADDR_OUT_MON = 4'h3;
   localparam logic [3:0] ADDR_SRC_SEL = 4'h4;
   localparam logic [3:0] ADDR_FB_SCALE = 4'h5;
   localparam logic [3:0] ADDR_KP = 4'h6;
   localparam logic [3:0] ADDR_KI = 4'h7;
   localparam logic [3:0] ADDR_KD = 4'h8;
   localparam logic [3:0] ADDR_FILT_T = 4'h9;
   localparam logic [3:0] ADDR_KEYPAD_SP = 4'ha;
   localparam logic [3:0] ADDR_STATUS = 4'hb;
   // Reset values; gains in thousandths, percent in tenths, scale in tenths
   localparam logic [15:0] RST_KP = 16'h03e8;       // 1.000
   localparam logic [15:0] RST_KI = 16'h01ae;       // 0.430
   localparam logic [15:0] RST_KD = 16'h0000;       // 0.000
   localparam logic [15:0] RST_FILT_T = 16'h0019;   // 0.25 s in hundredths
   localparam logic [15:0] RST_FB_SCALE = 16'h03e8; // 100.0
   localparam logic [15:0] RST_KEYPAD_SP = 16'h0000;
   localparam logic [15:0] GAIN_MAX = 16'h7530;     // 30.000
   localparam logic [15:0] FILT_T_MAX = 16'hfde8;   // 650.00 s
   localparam logic [15:0] SCALE_MAX = 16'h7530;    // 3000.0
   localparam logic [15:0] PCT_FULL = 16'h03e8;     // 100.0 % == 1000
   localparam logic [3:0] AIN_FUNC_SETPOINT = 4'h5;
   // Version code, value arbitrary
   localparam logic [15:0] APP_VERSION = 16'h0064;
   // Sampling period
   localparam int SAMPLE_MS = 50;
   localparam int CLK_MHZ = 50;
   localparam int SAMPLE_CYCLES = SAMPLE_MS * 1000 * CLK_MHZ;
   // Pipeline state of the regulator update
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_FILT = 2'b01,
      ST_PID = 2'b10,
      ST_DONE = 2'b11
   } pidreg_state_type;
endpackage

// File: tb/pidreg_plant.sv
`timescale 1ns/1ns
`default_nettype none
// Process plant and transducer on the far side of the regulator
module pidreg_plant (
   input wire logic CLK, // Clock
   input wire logic RST_N, // Async reset, active low
   input wire logic SAMPLE_DONE, // Regulator output updated
   input wire logic [15:0] OUTPUT_PCT, // Regulator output, tenths
   input wire logic HOLD, // Force a fixed reading
   input wire logic [15:0] HOLD_VAL, // Forced reading, tenths
   input wire logic SLOW, // Sluggish process when high
   output logic [15:0] FEEDBACK // Process reading, tenths
);
   // Reading lags the output; a convex step keeps it inside 0..1000
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         FEEDBACK <= 16'h0000;
      end else if (HOLD) begin
         FEEDBACK <= HOLD_VAL;
      end else if (SAMPLE_DONE) begin
         FEEDBACK <= 16'(int'(FEEDBACK) + (int'(OUTPUT_PCT) - int'(FEEDBACK)) / (SLOW ? 8 : 2));
      end
   end
endmodule
`default_nettype wire

// File: tb/pidreg_top_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin fail_count++; \
   $display("Error %s expected %0h seen %0h", nm, ex, got); end end
module pidreg_top_tb_top;
   import pidreg_pkg::*;
   localparam int TICKS = 40; // Short sample period keeps the run brief
   localparam int KP = 1000;
   localparam int KI = 200;
   localparam int KD = 1;
   logic clk, rst_n, wr, rd, hold, slow, alarm, done, alm;
   logic [1:0] src;
   logic [3:0] addr, ain1, ain2;
   logic [15:0] wdata, rdata, fb, ana, ser, fbus, outp, hold_val, q;
   int fail_count, n_checks, seed, y, e, ep, sp, fbv, cyc, last;
   longint fl;
   logic [3:0] ra [9];
   logic [15:0] rv [9];

   pidreg_top #(.SAMPLE_TICKS(TICKS)) dut (.CLK(clk), .RST_N(rst_n), .ADDR(addr),
      .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .FEEDBACK(fb), .ANALOG_SP(ana),
      .SERIAL_SP(ser), .FIELDBUS_SP(fbus), .SRC_SEL(src), .AIN1_FUNC(ain1), .AIN2_FUNC(ain2),
      .OUTPUT_PCT(outp), .SAMPLE_DONE(done), .SRC_ALARM(alarm));
   pidreg_plant plant (.CLK(clk), .RST_N(rst_n), .SAMPLE_DONE(done), .OUTPUT_PCT(outp),
      .HOLD(hold), .HOLD_VAL(hold_val), .SLOW(slow), .FEEDBACK(fb));

   // Clock and cycle count
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) cyc <= cyc + 1;

   // Bus write, then one idle cycle so strobes never merge
   task automatic bw(input logic [3:0] a, input logic [15:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask

   // Bus read; data is only valid in the cycle after the strobe
   task automatic br(input logic [3:0] a);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 q = rdata;
      @(posedge clk);
   endtask

   // Incremental update with saturation; gains chosen so no rounding arises
   function automatic int next_y(int yo, int en, int eo);
      longint d;
      d = longint'(KP) * ((1000 + 5 * KI + 2000 * KD) * en - 2000 * KD * eo) / 1000000;
      d = d + yo;
      return (d < 0) ? 0 : (d > 1000) ? 1000 : int'(d);
   endfunction

   // Wait for the update pulse, bounded, and check the spacing
   task automatic wait_done();
      int k;
      k = 0;
      do begin
         @(posedge clk);
         #1 k++;
      end while (done !== 1'b1 && k < 200);
      `CHK("done_seen", 1'b1, done)
      if (last != 0) `CHK("period", TICKS, cyc - last)
      last = cyc;
   endtask

   // Random inputs for the next sample, and what they should produce
   task automatic stim();
      logic [15:0] a, s, f, k, h;
      logic [3:0] a1, a2;
      logic [1:0] c;
      c = 2'($random(seed));
      a = 16'($unsigned($random(seed)) % 1001);
      s = 16'($unsigned($random(seed)) % 1201);
      f = 16'($unsigned($random(seed)) % 1001);
      k = 16'($unsigned($random(seed)) % 1001);
      h = 16'($unsigned($random(seed)) % 1001);
      a1 = 4'($random(seed)) | 4'h4;
      a2 = 4'($random(seed)) | 4'h4;
      src <= c;
      ana <= a;
      ser <= s;
      fbus <= f;
      ain1 <= a1;
      ain2 <= a2;
      hold <= (($random(seed) & 7) == 0);
      hold_val <= h;
      slow <= 1'($random(seed));
      bw(ADDR_KEYPAD_SP, k);
      sp = (c == 0) ? k : (c == 1) ? a : (c == 2) ? ((s > 1000) ? 1000 : s) : f;
      #1 fbv = fb;
      alm = (c == 1) && (a1 != AIN_FUNC_SETPOINT) && (a2 != AIN_FUNC_SETPOINT);
      ep = e;
      e = sp - fbv;
      y = next_y(y, e, ep);
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Watchdog well beyond the expected run length
   initial begin
      #400000;
      fail_count++;
      $display("Error watchdog expired");
      tally_and_finish();
   end

   initial begin
      seed = 32'he9c58de9;
      {rst_n, wr, rd, slow, cyc, last} = '0;
      {addr, wdata, ana, ser, fbus, src, ain1, ain2, hold_val} = '0;
      hold = 1'b1;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      ra = '{ADDR_VERSION, ADDR_FB_SCALE, ADDR_KP, ADDR_KI, ADDR_KD, ADDR_FILT_T,
         ADDR_KEYPAD_SP, ADDR_OUT_MON, 4'hc};
      rv = '{APP_VERSION, RST_FB_SCALE, RST_KP, RST_KI, RST_KD, RST_FILT_T,
         RST_KEYPAD_SP, 16'h0000, 16'h0000};
      foreach (ra[i]) begin
         br(ra[i]);
         `CHK("reset_value", rv[i], q)
      end
      $display("test reset_values done");
      // Oversized writes clip; read-only and unmapped places ignore writes
      ra = '{ADDR_KP, ADDR_KI, ADDR_KD, ADDR_FILT_T, ADDR_FB_SCALE, ADDR_VERSION,
         ADDR_SP_MON, ADDR_FB_MON, 4'hc};
      rv = '{GAIN_MAX, GAIN_MAX, GAIN_MAX, FILT_T_MAX, SCALE_MAX, APP_VERSION,
         16'h0000, 16'h0000, 16'h0000};
      foreach (ra[i]) begin
         bw(ra[i], 16'hffff);
         br(ra[i]);
         `CHK("write_limit", rv[i], q)
      end
      $display("test write_limits done");
      for (int c = 0; c < 4; c++) begin
         src <= 2'(c);
         repeat (5) @(posedge clk);
         br(ADDR_SRC_SEL);
         `CHK("source", 16'(c), q)
         `CHK("alarm", (c == 1), alarm)
      end
      src <= 2'd1;
      ain2 <= AIN_FUNC_SETPOINT;
      repeat (5) @(posedge clk);
      `CHK("alarm_clear", 1'b0, alarm)
      $display("test source_select done");
      // Drive the output to its low limit so the model starts from a known state
      bw(ADDR_KP, 16'(KP));
      bw(ADDR_KI, 16'(KI));
      bw(ADDR_KD, 16'(KD));
      bw(ADDR_FILT_T, 16'h0000);
      bw(ADDR_FB_SCALE, 16'h00fa);
      bw(ADDR_KEYPAD_SP, 16'h0000);
      src <= 2'd0;
      hold_val <= 16'h03e8;
      repeat (3) wait_done();
      `CHK("low_limit", 16'h0000, outp)
      y = 0;
      e = -1000;
      for (int i = 0; i < 80; i++) begin
         @(posedge clk);
         stim();
         wait_done();
         `CHK("output", 16'(y), outp)
         `CHK("alarm", alm, alarm)
         @(posedge clk);
         br(ADDR_SP_MON);
         `CHK("sp_monitor", 16'(sp * 250 / 1000), q)
         br(ADDR_FB_MON);
         `CHK("fb_monitor", 16'(fbv * 250 / 1000), q)
         br(ADDR_OUT_MON);
         `CHK("out_monitor", 16'(y), q)
      end
      $display("test regulation done");
      // Smoothing: from the last setpoint, a keypad step with T = 0.45 s
      src <= 2'd0;
      bw(ADDR_FILT_T, 16'h002d);
      bw(ADDR_KEYPAD_SP, 16'h03e8);
      fl = longint'(sp) << 16;
      repeat (2) begin
         wait_done();
         fl = fl + ((longint'(1000) << 16) - fl) * 5 / (45 + 5);
         @(posedge clk);
         br(ADDR_SP_MON);
         `CHK("sp_filter", 16'((fl >> 16) * 250 / 1000), q)
      end
      $display("test setpoint_filter done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
